// *** hw/adcseq_pkg.sv ***
`default_nettype none
package adcseq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map (byte addresses)
  localparam int unsigned ADDR_W          = 5;
  localparam logic [4:0]  OFS_CTRL        = 5'h00;
  localparam logic [4:0]  OFS_CONFIG      = 5'h04;
  localparam logic [4:0]  OFS_RESULT      = 5'h08;
  localparam logic [4:0]  OFS_STATUS      = 5'h0C;
  localparam logic [4:0]  OFS_PORT        = 5'h10;
  localparam logic [4:0]  OFS_ANALOG      = 5'h14;

  // field positions
  localparam int unsigned CTRL_ON_BIT     = 0;
  localparam int unsigned CTRL_GO_BIT     = 1;
  localparam int unsigned CTRL_CHAN_LSB   = 2;
  localparam int unsigned CFG_CLK_LSB     = 0;
  localparam int unsigned CFG_ACQ_LSB     = 3;
  localparam int unsigned STAT_DONE_BIT   = 0;
  localparam int unsigned STAT_SAMPLE_BIT = 1;

  // reset values
  localparam logic [3:0]  RST_CHANNEL     = 4'h0;
  localparam logic [2:0]  RST_CLK_SEL     = 3'h0;
  localparam logic [2:0]  RST_ACQ_SEL     = 3'h0;
  localparam logic [7:0]  RST_ANALOG      = 8'hFF;
  localparam logic [9:0]  RST_RESULT      = 10'h000;

  // sequencing counts, in bit periods or clocks
  localparam logic [4:0]  CONV_TADS       = 5'd11;
  localparam logic [4:0]  POST_TADS       = 5'd2;
  localparam logic [4:0]  INSTR_CLKS      = 5'd4;
  localparam logic [2:0]  ACQ_NONE        = 3'h0;
  localparam logic [3:0]  TRIG_MODE       = 4'hB;
  localparam logic [9:0]  SAR_FIRST       = 10'h200;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    ST_OFF,
    ST_SAMPLE,
    ST_ACQ,
    ST_DELAY,
    ST_CONV,
    ST_WAIT
  } adcseq_state_t;

  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [31:0]       writedata;
  } adcseq_avreq_t;

  // bit period as a power of two of the clock: 000=2 100=4 001=8 101=16 010=32 110=64
  function automatic logic [2:0] adcseq_shift(input logic [2:0] sel);
    adcseq_shift = {sel[1:0], sel[2]} + 3'd1;
  endfunction : adcseq_shift

  // acquisition length in bit periods
  function automatic logic [4:0] adcseq_acq_tads(input logic [2:0] sel);
    case (sel)
      3'h1:    adcseq_acq_tads = 5'd2;
      3'h2:    adcseq_acq_tads = 5'd4;
      3'h3:    adcseq_acq_tads = 5'd6;
      3'h4:    adcseq_acq_tads = 5'd8;
      3'h5:    adcseq_acq_tads = 5'd12;
      3'h6:    adcseq_acq_tads = 5'd16;
      3'h7:    adcseq_acq_tads = 5'd20;
      default: adcseq_acq_tads = 5'd0;
    endcase
  endfunction : adcseq_acq_tads

endpackage : adcseq_pkg
`default_nettype wire

// *** hw/adcseq_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcseq_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] level
);
  logic [W-1:0] meta;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  ////////////////////////////////////////////////////////////////////////////
  // three stages; a bit changes only when stages two and three agree
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta  <= '0;
      s2    <= '0;
      s3    <= '0;
      level <= '0;
    end
    else if (ce)
    begin
      meta <= async_in;
      s2   <= meta;
      s3   <= s2;
      for (int i = 0; i < W; i++)
      begin
        if (s2[i] == s3[i])
          level[i] <= s3[i];
      end
    end
  end
endmodule : adcseq_sync
`default_nettype wire

// *** hw/adcseq_tad_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcseq_tad_gen (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic       restart,
  input  wire logic [2:0] sel,
  input  wire logic       rc_tick,
  output var  logic       tick
);
  import adcseq_pkg::*;

  logic [5:0] div_cnt;
  logic [6:0] period;
  logic       use_rc;
  logic [6:0] gap;

  assign use_rc = (sel[1:0] == 2'b11);
  assign period = 7'd1 << adcseq_shift(sel);

  ////////////////////////////////////////////////////////////////////////////
  // divide by the selected power of two, or pass the synced rc tick
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_cnt <= '0;
      tick    <= 1'b0;
    end
    else if (ce)
    begin
      if (!run || restart)
      begin
        div_cnt <= '0;
        tick    <= 1'b0;
      end
      else if (use_rc)
      begin
        div_cnt <= '0;
        tick    <= rc_tick;
      end
      else
      begin
        tick    <= (div_cnt == 6'(period - 7'd1));
        div_cnt <= (div_cnt == 6'(period - 7'd1)) ? 6'd0 : div_cnt + 6'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // spacing between ticks, for checking only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      gap <= '0;
    else if (ce)
      gap <= (!run || restart) ? 7'd0 : (tick ? 7'd1 : gap + 7'd1);
  end

  chk_div_period : assert property (@(posedge clk) disable iff (!rst_n)
    (ce && tick && run && !restart && !use_rc && $past(run) && $past(ce) && $stable(sel)
      && $past(tick) == 1'b0 && gap > 7'd1) |-> gap == period)
    else $error("bit period does not match clock select");
endmodule : adcseq_tad_gen
`default_nettype wire

// *** hw/adcseq_top.sv ***
// The Avalon-MM slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module adcseq_top (
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire logic                     ce,
  input  wire adcseq_pkg::adcseq_avreq_t av_req,
  output var  logic                     av_waitrequest,
  output var  logic [31:0]              av_readdata,
  input  wire logic                     sel_event_trig,
  input  wire logic [3:0]               compare_unit_mode,
  input  wire logic [7:0]               pin_in,
  input  wire logic                     comp_in,
  input  wire logic                     rc_clk_pin,
  output var  logic                     sample_en,
  output var  logic                     conv_active,
  output var  logic [3:0]               mux_channel,
  output var  logic [9:0]               sar_trial,
  output var  logic                     timer_reset,
  output var  logic                     conv_done_irq_flag
);
  import adcseq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin inputs
  logic [9:0] pins_lvl;
  logic [7:0] pin_lvl;
  logic       comp_lvl;
  logic       rc_lvl;
  logic       rc_prev;
  logic       rc_tick;

  adcseq_sync #(.W(10)) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .async_in ({rc_clk_pin, comp_in, pin_in}),
    .level    (pins_lvl)
  );

  assign pin_lvl  = pins_lvl[7:0];
  assign comp_lvl = pins_lvl[8];
  assign rc_lvl   = pins_lvl[9];
  assign rc_tick  = rc_lvl && !rc_prev;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rc_prev <= 1'b0;
    else if (ce)
      rc_prev <= rc_lvl;
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic          converter_on;
  logic [3:0]    channel_select;
  logic [2:0]    conv_clock_select;
  logic [2:0]    acq_time_select;
  logic [9:0]    result_pair;
  logic [7:0]    analog_mask;
  adcseq_state_t state;
  logic [4:0]    phase_cnt;
  logic          tad_tick;
  logic          wr_fire;
  logic          rd_fire;
  logic          ctrl_wr;
  logic          trig_hit;
  logic          set_go;
  logic          clear_go;
  logic          go_busy;
  logic          abort;
  logic          conv_done;
  logic [9:0]    next_trial;
  logic [3:0]    bit_idx;

  assign wr_fire  = ce && av_req.write && !av_waitrequest;
  assign rd_fire  = ce && av_req.read && !av_waitrequest;
  assign ctrl_wr  = wr_fire && av_req.address == OFS_CTRL;
  assign trig_hit = sel_event_trig && compare_unit_mode == TRIG_MODE;
  // go only counts if the converter was already on before this write
  assign set_go   = (ctrl_wr && av_req.writedata[CTRL_GO_BIT] && converter_on)
                    || (trig_hit && converter_on);
  assign clear_go = ctrl_wr && !av_req.writedata[CTRL_GO_BIT];
  assign go_busy  = state == ST_ACQ || state == ST_DELAY || state == ST_CONV;
  assign abort    = go_busy && (clear_go || !converter_on);
  assign conv_done = state == ST_CONV && tad_tick && !abort
                     && phase_cnt == CONV_TADS - 5'd1;

  // one wait cycle per access, then the answer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      av_waitrequest <= 1'b1;
    else if (ce)
      av_waitrequest <= !((av_req.read || av_req.write) && av_waitrequest);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      av_readdata <= '0;
    else if (ce && av_req.read && av_waitrequest)
    begin
      case (av_req.address)
        OFS_CTRL:   av_readdata <= 32'({channel_select, go_busy, converter_on});
        OFS_CONFIG: av_readdata <= 32'({acq_time_select, conv_clock_select});
        OFS_RESULT: av_readdata <= 32'(result_pair);
        OFS_STATUS: av_readdata <= 32'({sample_en, conv_done_irq_flag});
        OFS_PORT:   av_readdata <= 32'(pin_lvl & ~analog_mask);
        OFS_ANALOG: av_readdata <= 32'(analog_mask);
        default:    av_readdata <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      converter_on      <= 1'b0;
      channel_select    <= RST_CHANNEL;
      conv_clock_select <= RST_CLK_SEL;
      acq_time_select   <= RST_ACQ_SEL;
      analog_mask       <= RST_ANALOG;
    end
    else if (wr_fire)
    begin
      case (av_req.address)
        OFS_CTRL:
        begin
          converter_on   <= av_req.writedata[CTRL_ON_BIT];
          channel_select <= av_req.writedata[CTRL_CHAN_LSB +: 4];
        end
        OFS_CONFIG:
        begin
          conv_clock_select <= av_req.writedata[CFG_CLK_LSB +: 3];
          acq_time_select   <= av_req.writedata[CFG_ACQ_LSB +: 3];
        end
        OFS_ANALOG: analog_mask <= av_req.writedata[7:0];
        default:    analog_mask <= analog_mask;
      endcase
    end
  end

  // channel goes straight to the mux; pin direction plays no part
  assign mux_channel = channel_select;

  ////////////////////////////////////////////////////////////////////////////
  // bit period
  adcseq_tad_gen u_tad (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .run     (state == ST_ACQ || state == ST_CONV || state == ST_WAIT),
    .restart (abort),
    .sel     (conv_clock_select),
    .rc_tick (rc_tick),
    .tick    (tad_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state     <= ST_OFF;
      phase_cnt <= '0;
    end
    else if (ce)
    begin
      case (state)
        ST_OFF:
          if (converter_on)
            state <= ST_SAMPLE;
        ST_SAMPLE:
          if (!converter_on)
            state <= ST_OFF;
          else if (set_go)
          begin
            phase_cnt <= '0;
            // no programmed acquisition: wait one instruction for a sleep
            state <= (acq_time_select == ACQ_NONE) ? ST_DELAY : ST_ACQ;
          end
        ST_ACQ:
          if (abort)
          begin
            state     <= ST_WAIT;
            phase_cnt <= '0;
          end
          else if (tad_tick)
          begin
            // sample the programmed time, then convert unaided
            if (phase_cnt == adcseq_acq_tads(acq_time_select) - 5'd1)
            begin
              state     <= ST_CONV;
              phase_cnt <= '0;
            end
            else
              phase_cnt <= phase_cnt + 5'd1;
          end
        ST_DELAY:
          if (abort)
          begin
            state     <= ST_WAIT;
            phase_cnt <= '0;
          end
          else if (phase_cnt == INSTR_CLKS - 5'd1)
          begin
            state     <= ST_CONV;
            phase_cnt <= '0;
          end
          else
            phase_cnt <= phase_cnt + 5'd1;
        ST_CONV:
          if (abort || conv_done)
          begin
            state     <= ST_WAIT;
            phase_cnt <= '0;
          end
          else if (tad_tick)
            phase_cnt <= phase_cnt + 5'd1;
        ST_WAIT:
          if (tad_tick)
          begin
            // two bit periods, then back to sampling, or to off if the converter is off
            if (phase_cnt == POST_TADS - 5'd1)
            begin
              state     <= converter_on ? ST_SAMPLE : ST_OFF;
              phase_cnt <= '0;
            end
            else
              phase_cnt <= phase_cnt + 5'd1;
          end
        default:
          state <= ST_OFF;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // successive approximation; first bit period settles, ten decide bits
  // comparator passes the pin synchroniser, so 2- and 4-clock bit periods see it late
  assign bit_idx = 4'(CONV_TADS - 5'd1 - phase_cnt);

  always_comb
  begin
    next_trial = sar_trial;
    if (phase_cnt == 5'd0)
      next_trial = SAR_FIRST;
    else
    begin
      if (!comp_lvl)
        next_trial[bit_idx] = 1'b0;
      if (bit_idx != 4'd0)
        next_trial[bit_idx - 4'd1] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sar_trial <= '0;
    else if (ce && state == ST_CONV && tad_tick && !abort)
      sar_trial <= next_trial;
  end

  // aborted samples never reach the result; completion wins over a bus write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      result_pair <= RST_RESULT;
    else if (conv_done && ce)
      result_pair <= next_trial;
    else if (wr_fire && av_req.address == OFS_RESULT)
      result_pair <= av_req.writedata[9:0];
  end

  // done flag: set wins over write-one-to-clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      conv_done_irq_flag <= 1'b0;
    else if (ce && conv_done)
      conv_done_irq_flag <= 1'b1;
    else if (wr_fire && av_req.address == OFS_STATUS
             && av_req.writedata[STAT_DONE_BIT])
      conv_done_irq_flag <= 1'b0;
  end

  // timer clear follows every trigger, converter on or off
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_reset <= 1'b0;
      sample_en   <= 1'b0;
      conv_active <= 1'b0;
    end
    else if (ce)
    begin
      timer_reset <= trig_hit;
      sample_en   <= state == ST_SAMPLE || state == ST_ACQ || state == ST_DELAY;
      conv_active <= state == ST_CONV;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [4:0] conv_ticks;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      conv_ticks <= '0;
    else if (ce)
      conv_ticks <= (state != ST_CONV) ? 5'd0 : conv_ticks + 5'(tad_tick);
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_delay_start;
    state == ST_SAMPLE && set_go && ce && acq_time_select == ACQ_NONE;
  endsequence

  chk_conv_eleven : assert property ((conv_done && ce) |-> conv_ticks == 5'd10)
    else $error("conversion length is not eleven bit periods");
  chk_sleep_delay : assert property (s_delay_start ##1 ce [*5] |->
      $past(state, 1) == ST_DELAY && $past(state, 4) == ST_DELAY && state == ST_CONV)
    else $error("no-acquisition start not delayed one instruction");
  chk_abort_hold : assert property ((abort && ce && !(wr_fire && av_req.address == OFS_RESULT))
      |=> $stable(result_pair))
    else $error("result changed on abort");
  chk_post_wait : assert property ((ce && state == ST_WAIT && tad_tick) |=>
      (state == ST_WAIT) == ($past(phase_cnt) == 5'd0))
    else $error("post-conversion wait is not two bit periods");
  chk_acq_four : assert property ((ce && state == ST_ACQ && !abort && tad_tick
      && acq_time_select == 3'h2) |=> (state == ST_CONV) == ($past(phase_cnt) == 5'd3))
    else $error("acquisition 010 is not four bit periods");
  chk_trig_go : assert property ((ce && trig_hit && converter_on && state == ST_SAMPLE)
      |=> go_busy)
    else $error("trigger did not set go");
  chk_timer_clear : assert property ((ce && trig_hit) |=> timer_reset)
    else $error("trigger did not clear timer");
  chk_trig_off : assert property ((ce && trig_hit && !converter_on)
      |=> state != ST_ACQ && state != ST_DELAY)
    else $error("trigger acted while converter off");
  chk_done_flag : assert property ((ce && conv_done) |=>
      conv_done_irq_flag && state == ST_WAIT && !go_busy)
    else $error("completion did not set flag and clear go");
  chk_port_mask : assert property ((!av_waitrequest && av_req.read
      && av_req.address == OFS_PORT && $past(ce)) |-> (av_readdata[7:0] & analog_mask) == 8'h00)
    else $error("analog pin read back non-zero");
endmodule : adcseq_top
`default_nettype wire

// *** sim/adcseq_fe_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcseq_fe_model (
  input  wire logic [9:0] sar_trial,
  input  wire logic [9:0] vin,
  output var  logic       comp_in,
  output var  logic       rc_clk_pin
);
  // ideal comparator: high when input at or above trial word
  always_comb comp_in = (vin >= sar_trial);
  ////////////////////////////////////////////////////////////////////////////
  // rc source runs free, period 10 clk, phase unrelated to clk
  initial
  begin
    rc_clk_pin = 1'b0;
    #7;
    forever #200 rc_clk_pin = ~rc_clk_pin;
  end
endmodule : adcseq_fe_model
`default_nettype wire

// *** sim/adcseq_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcseq_top_tb;
  import adcseq_pkg::*;
  localparam int TADS [8] = '{2, 8, 32, 10, 4, 16, 64, 10};
  logic          clk, rstn, trig, comp, rcp, wrq, samp, conv, trst, donef;
  logic [3:0]    mode, chan;
  logic [7:0]    pins;
  logic [9:0]    vin, trial;
  logic [31:0]   rdat, rd;
  logic          conv_q, samp_q;
  adcseq_avreq_t av_req;
  int            bad_count, tests_run, cyc, t_acc, t_up, t_dn, t_sp, t_trg, t_tr, n_tr, g_n;
  ////////////////////////////////////////////////////////////////////////////
  adcseq_top dut (.clk(clk), .rstn(rstn), .ce(1'b1), .av_req(av_req),
    .av_waitrequest(wrq), .av_readdata(rdat), .sel_event_trig(trig),
    .compare_unit_mode(mode), .pin_in(pins), .comp_in(comp), .rc_clk_pin(rcp),
    .sample_en(samp), .conv_active(conv), .mux_channel(chan), .sar_trial(trial),
    .timer_reset(trst), .conv_done_irq_flag(donef));
  adcseq_fe_model fe (.sar_trial(trial), .vin(vin), .comp_in(comp), .rc_clk_pin(rcp));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // edge stamps; nba so tasks and monitor agree on cyc
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    conv_q <= conv;
    samp_q <= samp;
    if (conv && !conv_q) t_up <= cyc;
    if (!conv && conv_q) t_dn <= cyc;
    if (samp && !samp_q) t_sp <= cyc;
    if (trig) t_trg <= cyc;
    if (trst)
    begin
      t_tr <= cyc;
      n_tr <= n_tr + 1;
    end
    if (cyc == 30000)
    begin
      bad_count++;
      close_out;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task rng(input string nm, input int v, input int lo, input int hi);
    check(nm, {31'h0, v >= lo && v <= hi}, 32'h1);
  endtask : rng
  // held until waitrequest sampled low, released after that edge only
  task xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
    av_req <= '{read: ~w, write: w, address: a, writedata: d};
    do @(posedge clk); while (wrq !== 1'b0);
    rd = rdat;
    t_acc = cyc;
    av_req <= '{read: 1'b0, write: 1'b0, address: a, writedata: d};
    @(posedge clk);
  endtask : xfer
  task wr(input logic [4:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task rd_chk(input string nm, input logic [4:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(nm, rd, exp);
  endtask : rd_chk
  // back in sampling: not busy and sampling
  task idle_wait;
    logic b;
    do
    begin
      xfer(1'b0, OFS_CTRL, 32'h0);
      b = rd[1];
      xfer(1'b0, OFS_STATUS, 32'h0);
    end
    while (b !== 1'b0 || rd[1] !== 1'b1);
  endtask : idle_wait
  task pulse;
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    rd_chk("ctrl", OFS_CTRL, 32'h0);
    rd_chk("config", OFS_CONFIG, 32'h0);
    rd_chk("analog", OFS_ANALOG, 32'hFF);
    rd_chk("result", OFS_RESULT, 32'h0);
    wr(5'h18, 32'hFF);
    rd_chk("unmapped", 5'h18, 32'h0);
    wr(OFS_CTRL, 32'h17);
    rd_chk("go with on", OFS_CTRL, 32'h15);
    check("chan", {28'h0, chan}, 32'h5);
    $display("test reset done");
  endtask : t_reset
  task t_port;
    wr(OFS_ANALOG, 32'h0F);
    pins <= 8'hA5;
    repeat (6) @(posedge clk);
    rd_chk("port mixed", OFS_PORT, 32'hA0);
    wr(OFS_ANALOG, 32'hFF);
    rd_chk("port analog", OFS_PORT, 32'h0);
    $display("test port done");
  endtask : t_port
  task t_conv(input logic [2:0] cs, input logic [2:0] aq, input logic [9:0] v, input int tad);
    int g;
    vin <= v;
    wr(OFS_CONFIG, {26'h0, aq, cs});
    wr(OFS_CTRL, 32'h15);
    wr(OFS_CTRL, 32'h17);
    g = t_acc;
    idle_wait;
    if (aq == ACQ_NONE) rng("delay", t_up - g, 4, 7);
    else rng("acq", t_up - g, 3 * tad + 2, 4 * tad + 4);
    rng("conv len", t_dn - t_up, 10 * tad + 1, 11 * tad + 1);
    rng("post wait", t_sp - t_dn, tad + 1, 2 * tad + 1);
    if (tad >= 8) rd_chk("result", OFS_RESULT, {22'h0, v});
    if (tad >= 8) check("trial", {22'h0, trial}, {22'h0, v});
    rd_chk("go cleared", OFS_CTRL, 32'h15);
    rd_chk("done set", OFS_STATUS, 32'h3);
    check("flag pin", {31'h0, donef}, 32'h1);
    wr(OFS_STATUS, 32'h1);
    rd_chk("done w1c", OFS_STATUS, 32'h2);
    check("flag pin clr", {31'h0, donef}, 32'h0);
    $display("test conv %0h %0h done", cs, aq);
  endtask : t_conv
  task t_abort;
    wr(OFS_RESULT, 32'h155);
    wr(OFS_CONFIG, 32'h5);
    wr(OFS_CTRL, 32'h17);
    do @(posedge clk); while (conv !== 1'b1);
    repeat (40) @(posedge clk);
    wr(OFS_CTRL, 32'h15);
    idle_wait;
    rd_chk("kept result", OFS_RESULT, 32'h155);
    rd_chk("no done", OFS_STATUS, 32'h2);
    rng("abort wait", t_sp - t_dn, 17, 34);
    $display("test abort done");
  endtask : t_abort
  task t_trig;
    mode <= TRIG_MODE;
    wr(OFS_CONFIG, 32'h1);
    wr(OFS_CTRL, 32'h14);
    pulse;
    check("tmr off", t_tr - t_trg, 32'h1);
    rd_chk("trig off", OFS_CTRL, 32'h14);
    wr(OFS_CTRL, 32'h15);
    pulse;
    check("tmr on", t_tr - t_trg, 32'h1);
    rd_chk("trig go", OFS_CTRL, 32'h17);
    idle_wait;
    rd_chk("trig done", OFS_STATUS, 32'h3);
    wr(OFS_STATUS, 32'h1);
    mode <= 4'h3;
    g_n = n_tr;
    pulse;
    check("tmr other", n_tr, g_n);
    rd_chk("trig other", OFS_CTRL, 32'h15);
    $display("test trigger done");
  endtask : t_trig
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {bad_count, tests_run, cyc, n_tr, g_n} = '0;
    {rstn, trig, conv_q, samp_q} = '0;
    mode = 4'h0;
    pins = 8'h0;
    vin = 10'h0;
    av_req = '0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_port;
    for (int i = 0; i < 8; i++) t_conv(i[2:0], ACQ_NONE, 10'h2A5 + 10'(i), TADS[i]);
    t_conv(3'h5, 3'h2, 10'h1C3, 16);
    t_abort;
    t_trig;
    close_out;
  end
endmodule : adcseq_top_tb
`default_nettype wire
